// *** common/pms_pkg.sv ***
package pms_pkg;
  `include "pms_regs.svh"

  typedef struct packed {
    logic [`PMS_ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pms_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pms_apb_rsp_type;

  // Comparator flags from the analog front end
  typedef struct packed {
    logic over_current;
    logic short_circuit;
    logic unbalance;
    logic under_voltage;
    logic over_voltage;
    logic over_abs;
    logic below_release;
    logic thermistor_low;
  } pms_cmp_type;

  typedef struct packed {
    logic phase_drive_one;
    logic phase_drive_two;
    logic phase_drive_three;
    logic tristate;
    logic low_side_on;
  } pms_drive_type;

  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_SOFT, ST_RUN, ST_FAULT
  } pms_state_type;

  typedef enum logic [1:0] {SP_NONE, SP_120, SP_180} pms_spacing_type;

  typedef enum logic [1:0] {SC_FULL, SC_TWO_THIRDS, SC_HALF} pms_scale_type;

  typedef struct packed {
    logic dcm_allow;
    pms_spacing_type spacing;
    pms_scale_type oc_scale;
    logic phase_two_sense_tie;
    logic slew_fast;
    logic slew_active;
    logic slew_source;
  } pms_mode_type;
endpackage : pms_pkg

// *** common/pms_regs.svh ***
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// Register map
`define PMS_ADDR_W 12
`define PMS_OFF_CTRL 12'h000
`define PMS_OFF_STATUS 12'h004
`define PMS_OFF_FAULT 12'h008

// Control register fields
`define PMS_CTRL_W 2
`define PMS_CTRL_RST 2'h0
`define PMS_CTRL_NOSHED 0
`define PMS_CTRL_NODCM 1

// Fault register fields, timed qualifiers first
`define PMS_NQUAL 4
`define PMS_NFLT 5
`define PMS_FLT_OC 0
`define PMS_FLT_UB 1
`define PMS_FLT_UV 2
`define PMS_FLT_OV1 3
`define PMS_FLT_SC 4
`define PMS_FLT_OVA 5

// Status register fields
`define PMS_ST_STATE 0
`define PMS_ST_STATE_W 3
`define PMS_ST_COUNT 4
`define PMS_ST_COUNT_W 2
`define PMS_ST_SHED 6
`define PMS_ST_DCM 7
`define PMS_ST_FAST 8
`define PMS_ST_PG 9
`define PMS_ST_TT 10
`define PMS_ST_CLAMP 11

// Pin widths
`define PMS_VCODE_W 7

// Timing
`define PMS_CLK_NS 8
`define PMS_OC_QUAL_US 120
`define PMS_SLOW_QUAL_MS 1
`define PMS_START_DLY_US 120

`endif

// *** dv/pms_far_model.sv ***
`timescale 1ns/10ps
module pms_far_model (
  input wire logic core_clk,
  input wire logic [2:0] cpu_mode,
  input wire logic [1:0] phases,
  output logic deep_sleep_select,
  output logic deeper_stop_n,
  output logic power_state_n,
  output logic phase_two_unused,
  output logic phase_three_unused
);
  // Processor power-management pins move just after a clock edge
  always @(posedge core_clk) begin
    {deep_sleep_select, deeper_stop_n, power_state_n} <= cpu_mode;
  end
  // Build straps: two-phase builds populate phases one and two
  assign phase_two_unused = (phases < 2'd2);
  assign phase_three_unused = (phases < 2'd3);
endmodule : pms_far_model

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`include "pms_regs.svh"
module testbench;
  import pms_pkg::*;
  localparam int OCQ = 20;
  localparam int MSQ = 40;
  logic core_clk, rst, regulator_enable, supply_ok, boot_reached;
  logic ref_settled, deep_sleep_select, deeper_stop_n, power_state_n;
  logic phase_two_unused, phase_three_unused, power_good_out;
  logic thermal_throttle_n, err, shed;
  logic [2:0] cpu_mode;
  logic [1:0] phases;
  logic [`PMS_VCODE_W-1:0] voltage_code;
  logic [31:0] rd;
  pms_apb_req_type apb_req;
  pms_apb_rsp_type apb_rsp;
  pms_cmp_type cmp_flags;
  pms_drive_type drive;
  pms_mode_type mode;
  int n_mismatch, tests_run, v;
  int bt[4] = '{7, 5, 4, 3};

  pms_supervisor #(.OC_QUAL_CYC(OCQ), .MS_QUAL_CYC(MSQ),
    .START_DLY_CYC(10)) uut (.core_clk(core_clk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .cmp_flags(cmp_flags),
    .voltage_code(voltage_code), .deep_sleep_select(deep_sleep_select),
    .deeper_stop_n(deeper_stop_n), .power_state_n(power_state_n),
    .regulator_enable(regulator_enable), .supply_ok(supply_ok),
    .boot_reached(boot_reached), .ref_settled(ref_settled),
    .phase_two_unused(phase_two_unused),
    .phase_three_unused(phase_three_unused), .drive(drive), .mode(mode),
    .power_good_out(power_good_out),
    .thermal_throttle_n(thermal_throttle_n));

  pms_far_model far (.core_clk(core_clk), .cpu_mode(cpu_mode),
    .phases(phases), .deep_sleep_select(deep_sleep_select),
    .deeper_stop_n(deeper_stop_n), .power_state_n(power_state_n),
    .phase_two_unused(phase_two_unused),
    .phase_three_unused(phase_three_unused));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(logic [39:0] got, logic [39:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h", $time, what, got);
    end
  endtask : chk

  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic look(int c);
    repeat (c) @(posedge core_clk);
    @(negedge core_clk);
  endtask : look

  // One APB transfer, held until pready is seen high at a rising edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr,
      pwdata: d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic start(logic [1:0] p);
    @(posedge core_clk);
    phases <= p;
    regulator_enable <= 1'b0;
    look(8);
    @(posedge core_clk);
    regulator_enable <= 1'b1;
    rd = '0;
    for (int i = 0; i < 100 && rd[2:0] !== 3'd3; i++) begin
      apb(1'b0, `PMS_OFF_STATUS, '0);
    end
    chk({rd[2:0], power_good_out}, 4'h7, "run");
  endtask : start

  task automatic trip(int b, int lo, int hi, int fb);
    int c;
    @(posedge core_clk);
    cmp_flags[b] <= 1'b1;
    c = 0;
    while (drive.tristate !== 1'b1 && c < hi) begin
      @(negedge core_clk);
      c++;
    end
    chk(c >= lo && c < hi, 1, "trip time");
    chk({power_good_out, drive[4:2]}, 0, "drives off");
    @(posedge core_clk);
    cmp_flags[b] <= 1'b0;
    look(8);
    apb(1'b0, `PMS_OFF_FAULT, '0);
    chk({drive.tristate, rd}, {1'b1, 32'h1 << fb}, "latch");
  endtask : trip

  task automatic clear();
    @(posedge core_clk);
    regulator_enable <= 1'b0;
    look(8);
    apb(1'b0, `PMS_OFF_FAULT, '0);
    chk(rd, 0, "fault clear");
    start(2'd3);
  endtask : clear

  task automatic qual(int b, int q, int fb);
    repeat (2) begin
      @(posedge core_clk);
      cmp_flags[b] <= 1'b1;
      repeat (q - 6) @(posedge core_clk);
      cmp_flags[b] <= 1'b0;
      look(8);
    end
    chk(drive.tristate, 0, "no trip");
    trip(b, q, q + 12, fb);
    clear();
  endtask : qual

  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    apb_req = '0;
    cmp_flags = '0;
    voltage_code = 7'h30;
    {regulator_enable, supply_ok, boot_reached, ref_settled} = 4'b0111;
    cpu_mode = 3'b011;
    phases = 2'd3;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(32'h0520));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    look(0);
    chk({drive, mode, power_good_out, thermal_throttle_n}, 40'h1001,
      "reset");
    apb(1'b1, `PMS_OFF_CTRL, 32'h3);
    apb(1'b0, `PMS_OFF_CTRL, '0);
    chk({err, rd}, 3, "ctrl");
    apb(1'b1, `PMS_OFF_CTRL, '0);
    apb(1'b1, `PMS_OFF_STATUS, 32'h7);
    chk(err, 0, "status write");
    apb(1'b0, 12'h0c0, '0);
    chk({err, rd}, 40'h1_0000_0000, "unmapped");
    for (int p = 3; p >= 2; p--) begin
      start(p[1:0]);
      for (int m = 0; m < 8; m++) begin
        @(posedge core_clk);
        cpu_mode <= m[2:0];
        look(10);
        shed = !m[0];
        chk(mode.dcm_allow, m[2] & !m[1], "dcm");
        chk(drive[4:2], {1'b1, !shed, p == 3}, "phases");
        chk(mode.spacing, p == 3 ? (shed ? SP_180 : SP_120) :
          (shed ? SP_NONE : SP_180), "spacing");
        chk(mode.oc_scale, !shed ? SC_FULL : p == 3 ? SC_TWO_THIRDS :
          SC_HALF, "scale");
        chk(mode.phase_two_sense_tie, shed, "tie");
        chk(mode.slew_fast, !m[2], "slew rate");
      end
    end
    apb(1'b1, `PMS_OFF_CTRL, 32'h3);
    cpu_mode <= 3'b100;
    look(10);
    chk({mode.dcm_allow, drive[4:2], mode.oc_scale}, 6'h18, "ctrl");
    apb(1'b1, `PMS_OFF_CTRL, '0);
    cpu_mode <= 3'b011;
    start(2'd3);
    repeat (3) begin
      v = $urandom_range(119, 8);
      @(posedge core_clk);
      voltage_code <= v[6:0];
      look(8);
      @(posedge core_clk);
      ref_settled <= 1'b0;
      voltage_code <= v[6:0] - 7'h3;
      look(8);
      chk({mode.slew_active, mode.slew_source}, 2'b11, "rise");
      @(posedge core_clk);
      voltage_code <= v[6:0] + 7'h3;
      look(8);
      chk({mode.slew_active, mode.slew_source}, 2'b10, "fall");
      @(posedge core_clk);
      ref_settled <= 1'b1;
      look(8);
      chk(mode.slew_active, 0, "settled");
    end
    @(posedge core_clk);
    cmp_flags.thermistor_low <= 1'b1;
    look(8);
    chk({thermal_throttle_n, drive.tristate}, 0, "throttle");
    @(posedge core_clk);
    cmp_flags.thermistor_low <= 1'b0;
    look(8);
    chk(thermal_throttle_n, 1, "throttle off");
    for (int i = 0; i < 4; i++) qual(bt[i], i > 0 ? MSQ : OCQ, i);
    trip(6, 1, 8, 4);
    @(posedge core_clk);
    cmp_flags.over_abs <= 1'b1;
    look(8);
    chk({drive.low_side_on, power_good_out}, 2'b10, "clamp");
    @(posedge core_clk);
    cmp_flags.over_abs <= 1'b0;
    look(8);
    chk(drive.low_side_on, 1, "clamp held");
    @(posedge core_clk);
    cmp_flags.below_release <= 1'b1;
    look(8);
    chk(drive[1:0], 2'b10, "release");
    @(posedge core_clk);
    cmp_flags.below_release <= 1'b0;
    cmp_flags.over_abs <= 1'b1;
    look(8);
    chk(drive.low_side_on, 1, "clamp again");
    @(posedge core_clk);
    cmp_flags.over_abs <= 1'b0;
    cmp_flags.below_release <= 1'b1;
    regulator_enable <= 1'b0;
    look(8);
    @(posedge core_clk);
    cmp_flags.below_release <= 1'b0;
    regulator_enable <= 1'b1;
    look(40);
    apb(1'b0, `PMS_OFF_FAULT, '0);
    chk({drive.tristate, rd[5]}, 2'b11, "abs kept");
    @(posedge core_clk);
    supply_ok <= 1'b0;
    look(8);
    @(posedge core_clk);
    supply_ok <= 1'b1;
    apb(1'b0, `PMS_OFF_FAULT, '0);
    chk(rd, 0, "por clear");
    conclude();
  end
endmodule : testbench

// *** rtl/pms_qual.sv ***
`timescale 1ns/10ps
module pms_qual #(
  parameter int COUNT = 15000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cond,
  output logic qualified
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge core_clk) begin
    if (rst || !cond) begin
      cnt <= '0;
    end else if (cnt != CW'(COUNT)) begin
      cnt <= cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !cond) begin
      qualified <= 1'h0;
    end else if (cnt == CW'(COUNT - 1)) begin
      qualified <= 1'h1;
    end
  end

  property p_restart;
    @(posedge core_clk) disable iff (rst)
    !cond |=> (cnt == '0) && !qualified;
  endproperty
  a_restart: assert property (p_restart)
    else $error("qualifier did not restart");

  property p_qual_time;
    @(posedge core_clk) disable iff (rst)
    $rose(qualified) |-> $past(cond) && $past(cnt) == CW'(COUNT - 1);
  endproperty
  a_qual_time: assert property (p_qual_time)
    else $error("qualifier fired at wrong count");
endmodule : pms_qual

// *** rtl/pms_supervisor.sv ***
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "pms_regs.svh"
// Notes on behaviour
// - Conduction may be discontinuous only with deep sleep high, deeper stop low
// - Power state low disables phase two; phases one and three keep running
// - Three-phase build shedding phase two moves interleave to 180 degrees
// - Shedding three to two scales current limits to two thirds
// - Shedding two to one halves both current limits
// - While phase two is shed its sense input ties to active phases
// - Overcurrent below short level latches after 120 us continuous
// - Short-circuit overload turns drives off and power good low at once
// - Phase sense mismatch above 9 mV for 1 ms latches off
// - Output 300 mV under target for 1 ms latches undervoltage
// - Output 200 mV over target for 1 ms latches overvoltage
// - Any such fault latches power good low and tri-states drives
// - Enable low or supply reset clears faults; restart soft-starts
// - Above 1.7 V clamp low side until under 0.85 V, repeat
// - Absolute overvoltage cleared only by supply power-on reset
// - Absolute overvoltage detector stays active while enabled
// - Thermistor below 1.18 V asserts throttle low, nothing else
// - Voltage changes use slow slew in deep sleep, fast only in active run
// - Slow slew for start-up and entry, fast for exit to active
// - Slew current sources on rising command, sinks on falling
module pms_supervisor #(
  parameter int OC_QUAL_CYC =
    (`PMS_OC_QUAL_US * 1000 + `PMS_CLK_NS - 1) / `PMS_CLK_NS,
  parameter int MS_QUAL_CYC =
    (`PMS_SLOW_QUAL_MS * 1000000 + `PMS_CLK_NS - 1) / `PMS_CLK_NS,
  parameter int START_DLY_CYC =
    (`PMS_START_DLY_US * 1000 + `PMS_CLK_NS - 1) / `PMS_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rst,
  input pms_pkg::pms_apb_req_type apb_req,
  output pms_pkg::pms_apb_rsp_type apb_rsp,
  input pms_pkg::pms_cmp_type cmp_flags,
  input wire logic [`PMS_VCODE_W-1:0] voltage_code,
  input wire logic deep_sleep_select,
  input wire logic deeper_stop_n,
  input wire logic power_state_n,
  input wire logic regulator_enable,
  input wire logic supply_ok,
  input wire logic boot_reached,
  input wire logic ref_settled,
  input wire logic phase_two_unused,
  input wire logic phase_three_unused,
  output pms_pkg::pms_drive_type drive,
  output pms_pkg::pms_mode_type mode,
  output logic power_good_out,
  output logic thermal_throttle_n
);
  import pms_pkg::*;

  localparam int DLY_W = $clog2(START_DLY_CYC + 1);
  localparam int SYNC_W = 8 + `PMS_VCODE_W + 9;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;
  pms_cmp_type cmp_s;
  logic [`PMS_VCODE_W-1:0] vcode_s;
  logic ds_s;
  logic dstop_n_s;
  logic pss_n_s;
  logic ren_s;
  logic supply_s;
  logic boot_s;
  logic settled_s;
  logic unused2_s;
  logic unused3_s;

  pms_state_type state;
  pms_state_type next_state;
  logic [DLY_W-1:0] dly_cnt;
  logic enabled;
  logic monitor;
  logic fault_any;
  logic drive_ok;
  logic shed;
  logic clamp;
  logic ova_latch;
  logic [`PMS_NFLT-1:0] flt;
  logic [`PMS_NFLT-1:0] flt_set;
  logic [`PMS_NQUAL-1:0] qual_cond;
  logic [`PMS_NQUAL-1:0] qual_done;
  logic two_present;
  logic three_present;
  logic [1:0] phase_count;
  logic [1:0] active_count;
  logic [`PMS_CTRL_W-1:0] ctrl;
  logic [`PMS_VCODE_W-1:0] ref_code;
  logic [31:0] prdata_q;
  logic [31:0] status_word;
  logic mapped;

  // Pin synchronisation
  assign pin_raw = {cmp_flags, voltage_code, deep_sleep_select,
    deeper_stop_n, power_state_n, regulator_enable, supply_ok,
    boot_reached, ref_settled, phase_two_unused, phase_three_unused};
  assign {cmp_s, vcode_s, ds_s, dstop_n_s, pss_n_s, ren_s, supply_s,
    boot_s, settled_s, unused2_s, unused3_s} = pin_s;

  pms_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(pin_raw),
    .dout(pin_s)
  );

  assign enabled = ren_s && supply_s;
  assign monitor = (state == ST_SOFT) || (state == ST_RUN);
  assign fault_any = |flt;
  assign drive_ok = monitor && !fault_any && !ova_latch &&
    !flt_set[`PMS_FLT_SC];
  assign shed = !pss_n_s && !ctrl[`PMS_CTRL_NOSHED] && two_present;
  assign phase_count = 2'(2'(two_present) + 2'(three_present) + 2'h1);
  assign active_count = 2'(phase_count - 2'(shed));

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (enabled && !ova_latch) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_cnt == DLY_W'(START_DLY_CYC - 1)) begin
          next_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (boot_s) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_state = ST_RUN;
      ST_FAULT: next_state = ST_FAULT;
      default: next_state = ST_OFF;
    endcase
    if (monitor && (fault_any || ova_latch)) begin
      next_state = ST_FAULT;
    end
    if (!enabled) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || state != ST_DELAY) begin
      dly_cnt <= '0;
    end else begin
      dly_cnt <= dly_cnt + DLY_W'(1);
    end
  end

  // Phase strap capture at start-up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      two_present <= 1'h1;
      three_present <= 1'h1;
    end else if (state == ST_OFF && enabled) begin
      two_present <= !unused2_s;
      three_present <= !unused3_s;
    end
  end

  // Fault qualification
  always_comb begin
    qual_cond = '0;
    qual_cond[`PMS_FLT_OC] = monitor && cmp_s.over_current;
    qual_cond[`PMS_FLT_UB] = monitor && cmp_s.unbalance;
    qual_cond[`PMS_FLT_UV] = (state == ST_RUN) && cmp_s.under_voltage;
    qual_cond[`PMS_FLT_OV1] = (state == ST_RUN) && cmp_s.over_voltage;
  end

  for (genvar i = 0; i < `PMS_NQUAL; i++) begin : g_qual
    pms_qual #(
      .COUNT(i == `PMS_FLT_OC ? OC_QUAL_CYC : MS_QUAL_CYC)
    ) u_qual (
      .core_clk(core_clk),
      .rst(rst),
      .cond(qual_cond[i]),
      .qualified(qual_done[i])
    );
  end

  always_comb begin
    flt_set = '0;
    flt_set[`PMS_NQUAL-1:0] = qual_done;
    flt_set[`PMS_FLT_SC] = monitor && cmp_s.short_circuit;
  end

  always_ff @(posedge core_clk) begin
    if (rst || !enabled) begin
      flt <= '0;
    end else begin
      flt <= flt | flt_set;
    end
  end

  // Absolute overvoltage latch and low-side clamp
  always_ff @(posedge core_clk) begin
    if (rst || !supply_s) begin
      ova_latch <= 1'h0;
    end else if (enabled && cmp_s.over_abs) begin
      ova_latch <= 1'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !supply_s) begin
      clamp <= 1'h0;
    end else if (enabled && cmp_s.over_abs) begin
      clamp <= 1'h1;
    end else if (cmp_s.below_release) begin
      clamp <= 1'h0;
    end
  end

  // Phase drives
  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive.phase_drive_one <= 1'h0;
      drive.phase_drive_two <= 1'h0;
      drive.phase_drive_three <= 1'h0;
      drive.tristate <= 1'h1;
      drive.low_side_on <= 1'h0;
    end else begin
      drive.phase_drive_one <= drive_ok;
      drive.phase_drive_two <= drive_ok && two_present && !shed;
      drive.phase_drive_three <= drive_ok && three_present;
      drive.tristate <= !drive_ok && !clamp;
      drive.low_side_on <= clamp;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_good_out <= 1'h0;
    end else begin
      power_good_out <= (state == ST_RUN) && drive_ok && !clamp &&
        !(enabled && cmp_s.over_abs);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      thermal_throttle_n <= 1'h1;
    end else begin
      thermal_throttle_n <= !cmp_s.thermistor_low;
    end
  end

  // Operating mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode.dcm_allow <= 1'h0;
      mode.spacing <= SP_NONE;
      mode.oc_scale <= SC_FULL;
      mode.phase_two_sense_tie <= 1'h0;
    end else begin
      mode.dcm_allow <= ds_s && !dstop_n_s &&
        !ctrl[`PMS_CTRL_NODCM];
      case (active_count)
        2'h3: mode.spacing <= SP_120;
        2'h2: mode.spacing <= SP_180;
        default: mode.spacing <= SP_NONE;
      endcase
      if (shed && three_present) begin
        mode.oc_scale <= SC_TWO_THIRDS;
      end else if (shed) begin
        mode.oc_scale <= SC_HALF;
      end else begin
        mode.oc_scale <= SC_FULL;
      end
      mode.phase_two_sense_tie <= shed;
    end
  end

  // Reference slew control
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_code <= '0;
    end else if (state != ST_RUN || settled_s) begin
      ref_code <= vcode_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode.slew_fast <= 1'h0;
      mode.slew_active <= 1'h0;
      mode.slew_source <= 1'h0;
    end else begin
      mode.slew_fast <= (state == ST_RUN) && !ds_s;
      mode.slew_active <= (state == ST_RUN) && (vcode_s != ref_code);
      mode.slew_source <= vcode_s < ref_code;
    end
  end

  // Register bus
  function automatic logic addr_hit(
    input logic [`PMS_ADDR_W-1:0] addr,
    input logic [`PMS_ADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction : addr_hit

  assign mapped = addr_hit(apb_req.paddr, `PMS_OFF_CTRL) ||
    addr_hit(apb_req.paddr, `PMS_OFF_STATUS) ||
    addr_hit(apb_req.paddr, `PMS_OFF_FAULT);

  always_comb begin
    status_word = '0;
    status_word[`PMS_ST_STATE +: `PMS_ST_STATE_W] = state;
    status_word[`PMS_ST_COUNT +: `PMS_ST_COUNT_W] = phase_count;
    status_word[`PMS_ST_SHED] = shed;
    status_word[`PMS_ST_DCM] = mode.dcm_allow;
    status_word[`PMS_ST_FAST] = mode.slew_fast;
    status_word[`PMS_ST_PG] = power_good_out;
    status_word[`PMS_ST_TT] = thermal_throttle_n;
    status_word[`PMS_ST_CLAMP] = clamp;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= `PMS_CTRL_RST;
    end else if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
        addr_hit(apb_req.paddr, `PMS_OFF_CTRL)) begin
      ctrl <= apb_req.pwdata[`PMS_CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (apb_req.psel && !apb_req.penable) begin
      prdata_q <= '0;
      if (addr_hit(apb_req.paddr, `PMS_OFF_CTRL)) begin
        prdata_q[`PMS_CTRL_W-1:0] <= ctrl;
      end else if (addr_hit(apb_req.paddr, `PMS_OFF_STATUS)) begin
        prdata_q <= status_word;
      end else if (addr_hit(apb_req.paddr, `PMS_OFF_FAULT)) begin
        prdata_q[`PMS_NFLT-1:0] <= flt;
        prdata_q[`PMS_FLT_OVA] <= ova_latch;
      end
    end
  end

  always_comb begin
    apb_rsp.prdata = prdata_q;
    apb_rsp.pready = 1'h1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  end

  // Checks
  property p_dcm_gate;
    @(posedge core_clk) disable iff (rst)
    !(ds_s && !dstop_n_s) |=> !mode.dcm_allow;
  endproperty
  a_dcm_gate: assert property (p_dcm_gate)
    else $error("dcm allowed outside deeper sleep");

  property p_shed_two;
    @(posedge core_clk) disable iff (rst)
    shed |=> !drive.phase_drive_two;
  endproperty
  a_shed_two: assert property (p_shed_two)
    else $error("phase two driven while shed");

  property p_spacing;
    @(posedge core_clk) disable iff (rst)
    shed && three_present |=> mode.spacing == SP_180;
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("interleave not widened after shed");

  property p_scale;
    @(posedge core_clk) disable iff (rst)
    shed |=> mode.oc_scale == ($past(three_present) ? SC_TWO_THIRDS
      : SC_HALF);
  endproperty
  a_scale: assert property (p_scale)
    else $error("limit scale wrong after shed");

  property p_tie;
    @(posedge core_clk) disable iff (rst)
    $fell(shed) |=> !mode.phase_two_sense_tie;
  endproperty
  a_tie: assert property (p_tie)
    else $error("sense tie held after re-enable");

  property p_short;
    @(posedge core_clk) disable iff (rst)
    monitor && cmp_s.short_circuit |=> !power_good_out
      && !drive.phase_drive_one ##1 !enabled || fault_any;
  endproperty
  a_short: assert property (p_short)
    else $error("short circuit not acted on");

  property p_fault_off;
    @(posedge core_clk) disable iff (rst)
    fault_any |=> !power_good_out && !drive.phase_drive_three;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("drive or power good active under fault");

  property p_clear;
    @(posedge core_clk) disable iff (rst)
    !enabled |=> flt == '0 && state == ST_OFF;
  endproperty
  a_clear: assert property (p_clear)
    else $error("faults not cleared by disable");

  property p_clamp;
    @(posedge core_clk) disable iff (rst)
    enabled && cmp_s.over_abs |=> clamp ##1 drive.low_side_on
      && !power_good_out;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("overvoltage clamp missing");

  property p_ova_hold;
    @(posedge core_clk) disable iff (rst)
    ova_latch && supply_s |=> ova_latch;
  endproperty
  a_ova_hold: assert property (p_ova_hold)
    else $error("absolute overvoltage cleared early");

  property p_throttle;
    @(posedge core_clk) disable iff (rst)
    cmp_s.thermistor_low |=> !thermal_throttle_n;
  endproperty
  a_throttle: assert property (p_throttle)
    else $error("throttle not asserted");

  property p_slew;
    @(posedge core_clk) disable iff (rst)
    state != ST_RUN || ds_s |=> !mode.slew_fast;
  endproperty
  a_slew: assert property (p_slew)
    else $error("fast slew outside active run");
endmodule : pms_supervisor

// *** rtl/pms_sync.sv ***
`timescale 1ns/10ps
module pms_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts once second and third stage agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk) begin
      if (rst) begin
        dout[i] <= 1'h0;
      end else if (s2[i] == s3[i]) begin
        dout[i] <= s3[i];
      end
    end
  end
endmodule : pms_sync
